// [shared/pvp_pkg.sv]
// shared constants of the process value postprocessor
package pvp_pkg;
    // register offsets (byte addresses, one aligned word each)
    localparam logic [7:0] REG_CTRL       = 8'h00;
    localparam logic [7:0] REG_ZERO_POINT = 8'h04;
    localparam logic [7:0] REG_SPAN_POINT = 8'h08;
    localparam logic [7:0] REG_ZERO_POS   = 8'h0c;
    localparam logic [7:0] REG_SPAN_POS   = 8'h10;
    localparam logic [7:0] REG_ZERO_ADJ   = 8'h14;
    localparam logic [7:0] REG_SPAN_GAIN  = 8'h18;
    localparam logic [7:0] REG_INTEG_COEF = 8'h1c;
    localparam logic [7:0] REG_NEW_DATE   = 8'h20;
    localparam logic [7:0] REG_LAST_DATE  = 8'h24;
    localparam logic [7:0] REG_STATUS     = 8'h28;
    localparam logic [7:0] REG_PV         = 8'h2c;
    localparam logic [7:0] REG_INTEGRAL   = 8'h30;
    // control field positions
    localparam int CTRL_SQRT_EN     = 0;
    localparam int CTRL_NEG_BIAS    = 1;
    localparam int CTRL_OVR_HIGH    = 2;
    localparam int CTRL_FOUR_CH     = 3;
    localparam int CTRL_INTEG_RUN   = 4;
    localparam int CTRL_INTEG_MIN   = 5;
    localparam int CTRL_INTEG_CLR   = 6;
    localparam int CTRL_EIGHT_CH    = 7;
    localparam int CTRL_DATE_UPDATE = 8;
    localparam int CTRL_WIDTH       = 8;
    // status field positions
    localparam int ST_NOTICE   = 0;
    localparam int ST_END      = 1;
    localparam int ST_NVM_ERR  = 2;
    localparam int ST_UPD_BUSY = 3;
    localparam int ST_ROOT     = 4;
    localparam int ST_CJC_OFF  = 5;
    localparam int ST_READY    = 6;
    // reset values
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] ZERO_POINT_RESET = 16'h0000;
    localparam logic [15:0] SPAN_POINT_RESET = 16'h0fa0;
    localparam logic [15:0] ZERO_POS_RESET   = 16'h0000;
    localparam logic [15:0] SPAN_POS_RESET   = 16'h2710;
    localparam logic [15:0] ZERO_ADJ_RESET   = 16'h0000;
    localparam logic [15:0] SPAN_GAIN_RESET  = 16'h2710;
    localparam logic [15:0] COEF_ONE         = 16'h03e8;
    // arithmetic scales
    localparam logic signed [63:0] FRAC_ONE  = 64'sd10000;
    localparam logic signed [63:0] INTEG_DIV = 64'sd1000000;
    localparam logic signed [63:0] PV_HI_4CH = 64'sd4200;
    localparam logic signed [63:0] PV_LO_4CH = -64'sd200;
    localparam logic signed [63:0] PV_MAX16  = 64'sd32767;
    localparam logic signed [63:0] PV_MIN16  = -64'sd32768;
    // square root characteristic, values in process units of a 0..4000 span
    localparam logic [31:0] SQRT_SPAN = 32'd4000;
    localparam logic signed [15:0] SQRT_RISE = 16'sd20;
    localparam logic signed [15:0] SQRT_FALL = 16'sd12;
    // adjustment date codes
    localparam logic [31:0] DATE_ABSENT = 32'h00000000;
    localparam logic [31:0] DATE_BAD    = 32'h0fffffff;
    // integration step timing
    localparam int CLK_MHZ       = 200;
    localparam int STEP_HOUR_MS  = 3600;
    localparam int STEP_MIN_MS   = 60;
    localparam int STEP_HOUR_CYC = STEP_HOUR_MS * CLK_MHZ * 1000;
    localparam int STEP_MIN_CYC  = STEP_MIN_MS * CLK_MHZ * 1000;
    typedef enum logic [1:0] {NVM_BOOT, NVM_IDLE, NVM_WRITE} pvp_nvm_t;
endpackage : pvp_pkg

// [src/pvp_sqrt.sv]
// square root characteristic with linear region and switch hysteresis
`timescale 1ns/1ps
`default_nettype none
module pvp_sqrt
    import pvp_pkg::*;
(
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst_n,
    // sample in
    input  wire logic               in_valid,
    input  wire logic signed [15:0] in_value,
    input  wire logic               sqrt_en,
    // sample out
    output logic                    out_valid,
    output logic signed [15:0]      out_value,
    output logic                    root_mode
);
    function automatic logic [15:0] isqrt(input logic [31:0] v);
        logic [31:0] rem;
        logic [15:0] root;
        logic [15:0] trial;
        rem  = v;
        root = 16'h0000;
        for (int i = 15; i >= 0; i--) begin
            trial = root | (16'h0001 << i);
            if ({16'h0000, trial} * {16'h0000, trial} <= rem) begin
                root = trial;
            end
        end
        return root;
    endfunction : isqrt

    logic        next_root;
    logic [31:0] sq_arg;
    logic [15:0] sq_res;

    // between the two thresholds the previous characteristic is kept
    assign next_root = !sqrt_en ? 1'b0 :
                       (in_value >= SQRT_RISE) ? 1'b1 :
                       (in_value < SQRT_FALL) ? 1'b0 :
                       root_mode;
    assign sq_arg = {16'h0000, in_value[15:0]} * SQRT_SPAN;
    assign sq_res = isqrt(sq_arg);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            root_mode <= 1'b0;
            out_valid <= 1'b0;
            out_value <= 16'sh0000;
        end else begin
            out_valid <= in_valid;
            if (in_valid) begin
                root_mode <= next_root;
                out_value <= next_root ? $signed(sq_res) : in_value;
            end
        end
    end
endmodule : pvp_sqrt
`default_nettype wire

// [src/pvp_integ.sv]
// time integrator of the process value, hour or minute unit
`timescale 1ns/1ps
`default_nettype none
module pvp_integ
    import pvp_pkg::*;
#(
    parameter int HOUR_CYC = STEP_HOUR_CYC,
    parameter int MIN_CYC  = STEP_MIN_CYC
) (
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst_n,
    // control
    input  wire logic               run,
    input  wire logic               unit_minute,
    input  wire logic               clear,
    input  wire logic [15:0]        coef,
    // data
    input  wire logic signed [15:0] pv,
    output logic signed [31:0]      integral
);
    logic [31:0]        step_cnt;
    logic [31:0]        step_last;
    logic               step_hit;
    logic signed [63:0] acc;
    logic signed [63:0] step_add;
    logic signed [63:0] next_acc;

    assign step_last = unit_minute ? 32'(MIN_CYC - 1) : 32'(HOUR_CYC - 1);
    assign step_hit  = run && (step_cnt >= step_last);
    // coef of 1000 means one: 1000 steps of pv*1000 give pv*1e6, shown as pv
    // both factors widened first so the product cannot wrap at 32 bits
    assign step_add  = $signed({{48{pv[15]}}, pv}) * $signed({48'h0, coef});
    assign next_acc  = acc + step_add;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            step_cnt <= 32'h00000000;
            acc      <= 64'sh0;
            integral <= 32'sh0;
        end else begin
            if (clear) begin
                step_cnt <= 32'h00000000;
                acc      <= 64'sh0;
            end else if (step_hit) begin
                step_cnt <= 32'h00000000;
                acc      <= next_acc;
            end else if (run) begin
                step_cnt <= step_cnt + 32'h00000001;
            end
            // beyond 32-bit range the low word is shown; value then undefined
            integral <= 32'(acc / INTEG_DIV);
        end
    end
endmodule : pvp_integ
`default_nettype wire

// [src/pvp_top.sv]
// process value postprocessor: root, adjustment, clamping, date keeping, integral
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pvp_top
    import pvp_pkg::*;
#(
    parameter int HOUR_CYC = STEP_HOUR_CYC,
    parameter int MIN_CYC  = STEP_MIN_CYC
) (
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst_n,
    // register port
    input  wire logic [7:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [31:0]             reg_rdata,
    // converted input sample
    input  wire logic               in_valid,
    input  wire logic signed [15:0] in_value,
    input  wire logic               in_disconnect,
    // cold junction sensor
    input  wire logic               cj_short,
    output logic                    cjc_enable,
    // process value out
    output logic                    pv_valid,
    output logic signed [15:0]      pv_out,
    output logic signed [31:0]      integral_out,
    // non-volatile date store
    input  wire logic               nvm_load_valid,
    input  wire logic               nvm_date_present,
    input  wire logic               nvm_date_bad,
    input  wire logic [31:0]        nvm_date,
    output logic                    nvm_wr_req,
    output logic [31:0]             nvm_wr_date,
    input  wire logic               nvm_wr_done,
    input  wire logic               nvm_wr_fail,
    // indicator
    output logic                    unit_error_indicator
);
    function automatic logic signed [63:0] sx16(input logic [15:0] v);
        return {{48{v[15]}}, v};
    endfunction : sx16

    function automatic logic signed [63:0] clamp(input logic signed [63:0] v,
                                                 input logic signed [63:0] lo,
                                                 input logic signed [63:0] hi);
        return (v > hi) ? hi : ((v < lo) ? lo : v);
    endfunction : clamp

    // configuration registers
    logic [CTRL_WIDTH-1:0] ctrl;
    logic [15:0]           zero_point;
    logic [15:0]           span_point;
    logic [15:0]           zero_pos;
    logic [15:0]           span_pos;
    logic [15:0]           zero_adj;
    logic [15:0]           span_gain;
    logic [15:0]           integ_coef;
    logic [31:0]           new_date;
    // date keeping state
    pvp_nvm_t              nvm_state;
    logic [31:0]           last_date;
    logic                  notice_flag;
    logic                  end_flag;
    logic                  nvm_err;
    logic                  upd_busy;
    logic                  integ_clear;

    // register decode
    logic wr_ctrl;
    logic wr_zero_point;
    logic wr_span_point;
    logic wr_zero_pos;
    logic wr_span_pos;
    logic wr_zero_adj;
    logic wr_span_gain;
    logic wr_coef;
    logic wr_new_date;
    logic update_req;

    assign wr_ctrl       = reg_wr && (reg_addr == REG_CTRL);
    assign wr_zero_point = reg_wr && (reg_addr == REG_ZERO_POINT);
    assign wr_span_point = reg_wr && (reg_addr == REG_SPAN_POINT);
    assign wr_zero_pos   = reg_wr && (reg_addr == REG_ZERO_POS);
    assign wr_span_pos   = reg_wr && (reg_addr == REG_SPAN_POS);
    assign wr_zero_adj   = reg_wr && (reg_addr == REG_ZERO_ADJ);
    assign wr_span_gain  = reg_wr && (reg_addr == REG_SPAN_GAIN);
    assign wr_coef       = reg_wr && (reg_addr == REG_INTEG_COEF);
    assign wr_new_date   = reg_wr && (reg_addr == REG_NEW_DATE);
    // an update asked while loading or writing is dropped
    assign update_req    = wr_ctrl && reg_wdata[CTRL_DATE_UPDATE] && (nvm_state == NVM_IDLE);

    logic sqrt_en;
    logic neg_bias;
    logic ovr_high;
    logic four_ch;
    logic eight_ch;

    assign sqrt_en  = ctrl[CTRL_SQRT_EN];
    assign neg_bias = ctrl[CTRL_NEG_BIAS];
    assign ovr_high = ctrl[CTRL_OVR_HIGH];
    assign four_ch  = ctrl[CTRL_FOUR_CH];
    assign eight_ch = ctrl[CTRL_EIGHT_CH];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl        <= CTRL_RESET;
            zero_point  <= ZERO_POINT_RESET;
            span_point  <= SPAN_POINT_RESET;
            zero_pos    <= ZERO_POS_RESET;
            span_pos    <= SPAN_POS_RESET;
            zero_adj    <= ZERO_ADJ_RESET;
            span_gain   <= SPAN_GAIN_RESET;
            integ_coef  <= COEF_ONE;
            new_date    <= DATE_ABSENT;
            integ_clear <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                // clear bit is a pulse and is not stored
                ctrl <= reg_wdata[CTRL_WIDTH-1:0] & ~(8'h01 << CTRL_INTEG_CLR);
            end
            integ_clear <= wr_ctrl && reg_wdata[CTRL_INTEG_CLR];
            if (wr_zero_point) zero_point <= reg_wdata[15:0];
            if (wr_span_point) span_point <= reg_wdata[15:0];
            if (wr_zero_pos) zero_pos <= reg_wdata[15:0];
            if (wr_span_pos) span_pos <= reg_wdata[15:0];
            if (wr_zero_adj) zero_adj <= reg_wdata[15:0];
            if (wr_span_gain) span_gain <= reg_wdata[15:0];
            if (wr_coef) integ_coef <= reg_wdata[15:0];
            if (wr_new_date) new_date <= reg_wdata;
        end
    end

    // stage 1: square root characteristic
    logic               root_valid;
    logic signed [15:0] root_value;
    logic               root_mode;
    logic               disc_s1;

    pvp_sqrt u_sqrt (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_valid  (in_valid),
        .in_value  (in_value),
        .sqrt_en   (sqrt_en),
        .out_valid (root_valid),
        .out_value (root_value),
        .root_mode (root_mode)
    );

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            disc_s1 <= 1'b0;
        end else if (in_valid) begin
            disc_s1 <= in_disconnect;
        end
    end

    // stage 2: zero/span adjustment, all in wide signed arithmetic
    logic signed [63:0] x_in;
    logic signed [63:0] a_pt;
    logic signed [63:0] h_pt;
    logic signed [63:0] range_w;
    logic signed [63:0] b_pos;
    logic signed [63:0] c_pos;
    logic signed [63:0] gain_term;
    logic signed [63:0] den;
    logic signed [63:0] adj_val;
    logic signed [63:0] pv_max;
    logic signed [63:0] pv_min;
    logic signed [63:0] lim_val;
    logic signed [63:0] sel_val;

    assign x_in    = sx16(root_value);
    assign a_pt    = sx16(zero_point);
    assign h_pt    = sx16(span_point);
    assign range_w = h_pt - a_pt;
    assign b_pos   = range_w * $signed({48'h0, zero_pos}) / FRAC_ONE + a_pt;
    assign c_pos   = range_w * $signed({48'h0, span_pos}) / FRAC_ONE + a_pt;
    assign gain_term = (c_pos - a_pt) * $signed({48'h0, span_gain}) / FRAC_ONE - b_pos + a_pt;
    assign den     = c_pos - b_pos;
    // coincident positions would divide by zero; then only the offset applies
    assign adj_val = (den == 64'sh0) ? x_in + sx16(zero_adj) :
                     (x_in - b_pos) * gain_term / den + sx16(zero_adj) + b_pos;

    assign pv_max  = four_ch ? PV_HI_4CH : ((a_pt > h_pt) ? a_pt : h_pt);
    assign pv_min  = four_ch ? PV_LO_4CH : ((a_pt > h_pt) ? h_pt : a_pt);
    assign lim_val = four_ch ? clamp(adj_val, PV_LO_4CH, PV_HI_4CH) :
                     clamp(adj_val, PV_MIN16, PV_MAX16);
    assign sel_val = (disc_s1 && neg_bias) ? (ovr_high ? pv_max : pv_min) : lim_val;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pv_valid <= 1'b0;
            pv_out   <= 16'sh0000;
        end else begin
            pv_valid <= root_valid;
            if (root_valid) begin
                pv_out <= sel_val[15:0];
            end
        end
    end

    // integrator
    logic [15:0]        coef_eff;
    logic signed [31:0] integ_val;

    assign coef_eff = eight_ch ? integ_coef : COEF_ONE;

    pvp_integ #(
        .HOUR_CYC (HOUR_CYC),
        .MIN_CYC  (MIN_CYC)
    ) u_integ (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .run         (ctrl[CTRL_INTEG_RUN]),
        .unit_minute (ctrl[CTRL_INTEG_MIN]),
        .clear       (integ_clear),
        .coef        (coef_eff),
        .pv          (pv_out),
        .integral    (integ_val)
    );

    // adjustment date keeping
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            nvm_state   <= NVM_BOOT;
            last_date   <= DATE_ABSENT;
            notice_flag <= 1'b0;
            end_flag    <= 1'b0;
            nvm_err     <= 1'b0;
            upd_busy    <= 1'b0;
            nvm_wr_req  <= 1'b0;
            nvm_wr_date <= DATE_ABSENT;
        end else begin
            unique case (nvm_state)
                NVM_BOOT: begin
                    if (nvm_load_valid) begin
                        nvm_state <= NVM_IDLE;
                        if (nvm_date_bad) begin
                            nvm_err     <= 1'b1;
                            last_date   <= DATE_BAD;
                            notice_flag <= 1'b1;
                            end_flag    <= 1'b1;
                        end else if (!nvm_date_present) begin
                            last_date   <= DATE_ABSENT;
                            notice_flag <= 1'b1;
                            end_flag    <= 1'b1;
                        end else begin
                            last_date   <= nvm_date;
                            notice_flag <= 1'b0;
                            end_flag    <= 1'b0;
                        end
                    end
                end
                NVM_IDLE: begin
                    if (update_req) begin
                        nvm_state   <= NVM_WRITE;
                        upd_busy    <= 1'b1;
                        nvm_wr_req  <= 1'b1;
                        nvm_wr_date <= new_date;
                    end
                end
                NVM_WRITE: begin
                    if (nvm_wr_done) begin
                        nvm_state  <= NVM_IDLE;
                        upd_busy   <= 1'b0;
                        nvm_wr_req <= 1'b0;
                        if (nvm_wr_fail) begin
                            // the store now holds a bad date, so a restart reloads it as faulty
                            nvm_err     <= 1'b1;
                            notice_flag <= 1'b1;
                            end_flag    <= 1'b1;
                        end else begin
                            nvm_err     <= 1'b0;
                            last_date   <= nvm_wr_date;
                            notice_flag <= 1'b0;
                            end_flag    <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    // outputs held in flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cjc_enable           <= 1'b1;
            unit_error_indicator <= 1'b0;
            integral_out         <= 32'sh0;
        end else begin
            cjc_enable           <= !(eight_ch && cj_short);
            unit_error_indicator <= nvm_err;
            integral_out         <= integ_val;
        end
    end

    // read path
    logic [31:0] status_word;
    logic [31:0] ctrl_word;
    logic [31:0] read_word;

    assign status_word = {25'h0, (nvm_state != NVM_BOOT), !cjc_enable, root_mode,
                          upd_busy, nvm_err, end_flag, notice_flag};
    assign ctrl_word   = {23'h0, upd_busy, ctrl};

    always_comb begin
        unique case (reg_addr)
            REG_CTRL:       read_word = ctrl_word;
            REG_ZERO_POINT: read_word = {16'h0, zero_point};
            REG_SPAN_POINT: read_word = {16'h0, span_point};
            REG_ZERO_POS:   read_word = {16'h0, zero_pos};
            REG_SPAN_POS:   read_word = {16'h0, span_pos};
            REG_ZERO_ADJ:   read_word = {16'h0, zero_adj};
            REG_SPAN_GAIN:  read_word = {16'h0, span_gain};
            REG_INTEG_COEF: read_word = {16'h0, integ_coef};
            REG_NEW_DATE:   read_word = new_date;
            REG_LAST_DATE:  read_word = last_date;
            REG_STATUS:     read_word = status_word;
            REG_PV:         read_word = {16'h0, pv_out};
            REG_INTEGRAL:   read_word = integral_out;
            default:        read_word = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else begin
            reg_rdata <= reg_rd ? read_word : 32'h00000000;
        end
    end
endmodule : pvp_top
`default_nettype wire

// [tb/pvp_nvm_model.sv]
// behavioural date store: boot load pulse and a slow write answer
`timescale 1ns/1ps
`default_nettype none
module pvp_nvm_model (
    input  wire logic clk_sys, rst_n, wr_req,
    output logic      load_valid, wr_done
);
    logic [1:0] boot;
    logic [2:0] wcnt;
    // late answer keeps the busy window open for a status read
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            boot <= 2'd0;
            wcnt <= 3'd0;
            load_valid <= 1'b0;
            wr_done <= 1'b0;
        end else begin
            if (boot != 2'd3) boot <= boot + 2'd1;
            load_valid <= boot == 2'd1;
            wcnt <= (wr_req && !wr_done) ? wcnt + 3'd1 : 3'd0;
            wr_done <= wr_req && !wr_done && wcnt == 3'd3;
        end
    end
endmodule : pvp_nvm_model
`default_nettype wire

// [tb/pvp_top_props.sv]
// port checker of the process value postprocessor
`timescale 1ns/1ps
`default_nettype none
module pvp_top_props
    import pvp_pkg::*;
(
    input wire logic               clk_sys, rst_n, reg_wr, in_valid, in_disconnect, cj_short,
    input wire logic               cjc_enable, pv_valid, nvm_wr_req, nvm_wr_done, nvm_wr_fail,
    input wire logic               unit_error_indicator,
    input wire logic [7:0]         reg_addr,
    input wire logic [31:0]        reg_wdata,
    input wire logic signed [15:0] pv_out,
    input wire logic signed [31:0] integral_out
);
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [7:0] ctrl;
    wire        ctrl_wr = reg_wr && reg_addr == REG_CTRL;
    always_ff @(posedge clk_sys or negedge rst_n)
        if (!rst_n) ctrl <= 8'h00;
        else if (ctrl_wr) ctrl <= reg_wdata[7:0];
    property p_max; pv_valid && $past(in_valid && in_disconnect, 2) && ctrl[3:1] == 3'b111 |-> pv_out == 16'sd4200; endproperty
    a_max: assert property (p_max) else $error("open input did not give the maximum");
    property p_min; pv_valid && $past(in_valid && in_disconnect, 2) && ctrl[3:1] == 3'b101 |-> pv_out == -16'sd200; endproperty
    a_min: assert property (p_min) else $error("open input did not give the minimum");
    property p_clamp; pv_valid && ctrl[3] |-> pv_out <= 16'sd4200 && pv_out >= -16'sd200; endproperty
    a_clamp: assert property (p_clamp) else $error("value outside the narrow limits");
    property p_hold; nvm_wr_req && !nvm_wr_done |=> nvm_wr_req; endproperty
    a_hold: assert property (p_hold) else $error("write request dropped early");
    property p_start; $rose(nvm_wr_req) |-> $past(ctrl_wr && reg_wdata[8]); endproperty
    a_start: assert property (p_start) else $error("write request without update");
    property p_bad; nvm_wr_req && nvm_wr_done && nvm_wr_fail |-> ##[1:2] unit_error_indicator; endproperty
    a_bad: assert property (p_bad) else $error("failed write left indicator dark");
    property p_good; nvm_wr_req && nvm_wr_done && !nvm_wr_fail |-> ##[1:2] !unit_error_indicator; endproperty
    a_good: assert property (p_good) else $error("good write left indicator lit");
    property p_cj; (ctrl[7] && cj_short) [*3] |-> !cjc_enable; endproperty
    a_cj: assert property (p_cj) else $error("compensation kept with shorted sensor");
    property p_clr; ctrl_wr && reg_wdata[6] |-> ##[1:4] integral_out == 32'sd0; endproperty
    a_clr: assert property (p_clr) else $error("integral not cleared");
endmodule : pvp_top_props
bind pvp_top pvp_top_props u_props (.*);
`default_nettype wire

// [tb/pvp_top_tb.sv]
// self-checking bench of the process value postprocessor
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module pvp_top_tb
    import pvp_pkg::*;
;
    logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, in_valid = 0, in_disc = 0, cj_short = 0;
    logic present = 0, bad = 0, fail = 0, load_v, done, req, cjc, pv_valid, uerr;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, rdata, v, wdate;
    logic signed [15:0] in_value = 16'sh0, pv_out;
    logic signed [31:0] integ;
    int fail_count = 0, n_compared = 0, cyc = 0, i;
    pvp_top #(.HOUR_CYC(10), .MIN_CYC(3)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .in_valid(in_valid),
        .in_value(in_value), .in_disconnect(in_disc), .cj_short(cj_short), .cjc_enable(cjc),
        .pv_valid(pv_valid), .pv_out(pv_out), .integral_out(integ), .nvm_load_valid(load_v),
        .nvm_date_present(present), .nvm_date_bad(bad), .nvm_date(32'h00012345), .nvm_wr_req(req),
        .nvm_wr_date(wdate), .nvm_wr_done(done), .nvm_wr_fail(fail), .unit_error_indicator(uerr));
    pvp_nvm_model u_nvm (.clk_sys(clk_sys), .rst_n(rst_n), .wr_req(req), .load_valid(load_v), .wr_done(done));
    initial forever #2.5 clk_sys = ~clk_sys;
    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            test_done();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = rdata;
        @(posedge clk_sys);
    endtask : rd
    task automatic smp(input logic signed [15:0] x, input logic dc, input logic signed [15:0] e);
        in_value <= x;
        in_disc <= dc;
        in_valid <= 1'b1;
        @(posedge clk_sys);
        in_valid <= 1'b0;
        @(posedge clk_sys);
        #1 `CHK({pv_valid, pv_out}, {1'b1, e})
        @(posedge clk_sys);
    endtask : smp
    task automatic rst(input logic p, input logic b);
        rst_n <= 1'b0;
        present <= p;
        bad <= b;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
    endtask : rst
    task automatic upd(input logic f);
        fail <= f;
        wr(REG_NEW_DATE, 32'h12345678);
        wr(REG_CTRL, 32'h100);
        rd(REG_STATUS, v);
        `CHK(v[3], 1'b1)
        `CHK(wdate, 32'h12345678)
        for (i = 0; i < 20 && req !== 1'b0; i++) @(posedge clk_sys);
        repeat (2) @(posedge clk_sys);
    endtask : upd
    initial begin
        rst(1'b0, 1'b0);
        rd(REG_LAST_DATE, v);
        `CHK(v, DATE_ABSENT)
        rd(REG_STATUS, v);
        `CHK(v[2:0], 3'h3)
        upd(1'b1);
        `CHK(uerr, 1'b1)
        upd(1'b0);
        rd(REG_LAST_DATE, v);
        `CHK({uerr, v}, {1'b0, 32'h12345678})
        rst(1'b1, 1'b1);
        rd(REG_STATUS, v);
        `CHK(v[2:0], 3'h7)
        rd(REG_LAST_DATE, v);
        `CHK({uerr, v}, {1'b1, DATE_BAD})
        wr(REG_CTRL, 32'h1);
        smp(16'sd10, 1'b0, 16'sd10);
        smp(16'sd20, 1'b0, 16'sd282);
        smp(16'sd15, 1'b0, 16'sd244);
        smp(16'sd11, 1'b0, 16'sd11);
        wr(REG_CTRL, 32'he);
        smp(16'sd100, 1'b1, 16'sd4200);
        wr(REG_CTRL, 32'ha);
        smp(16'sd100, 1'b1, -16'sd200);
        smp(16'sd5000, 1'b0, 16'sd4200);
        wr(REG_CTRL, 32'h0);
        smp(16'sd1000, 1'b0, 16'sd1000);
        wr(REG_CTRL, 32'h70);
        repeat (3000) @(posedge clk_sys);
        wr(REG_CTRL, 32'h0);
        rd(REG_INTEGRAL, v);
        `CHK(v >= 999 && v <= 1001, 1'b1)
        wr(REG_CTRL, 32'h50);
        repeat (1000) @(posedge clk_sys);
        wr(REG_CTRL, 32'h40);
        #1 `CHK(integ >= 99 && integ <= 101, 1'b1)
        repeat (2) @(posedge clk_sys);
        rd(REG_INTEGRAL, v);
        `CHK(v, 32'h0)
        cj_short <= 1'b1;
        wr(REG_CTRL, 32'h80);
        #1 `CHK(cjc, 1'b0)
        @(posedge clk_sys);
        wr(REG_ZERO_POS, 32'd500);
        wr(REG_SPAN_POS, 32'd9500);
        wr(REG_ZERO_ADJ, 32'd5);
        wr(REG_SPAN_GAIN, 32'd10060);
        smp(16'sd500, 1'b0, 16'sd506);
        rst(1'b1, 1'b0);
        rd(REG_LAST_DATE, v);
        `CHK({uerr, v}, {1'b0, 32'h00012345})
        test_done();
    end
endmodule : pvp_top_tb
`default_nettype wire
